// >>> pxrb_eee_mac_regs.sv
// Functional notes
// - Bit 15 power control enables low-energy ten-meg mode; resets to 0.
// - Bits 11:10 invert LED polarity; at 00 LED pins are active low.
// - Read-only bits 7 and 6 show gigabit and fast-mode EEE enabled.
// - Bit 5 with speed bits 10 allows gigabit link without forced role.
// - Bit 4 makes test packet source send idle; MAC transmit ignored.
// - Bit 3 blocks transmit low-power idle to line in 100 mode.
// - Bit 2 blocks receive low-power idle to MAC in 100 mode.
// - Bit 1 blocks transmit low-power idle to line in 1000 mode.
// - Bit 0 blocks receive low-power idle to MAC in 1000 mode.
// - MAC control bit 15 enables rapid link-loss indication; resets to 0.
// - MAC control bit 12 enables frame-start indication; resets to 0.
// - Bit 7 reverses receive data across four or eight lines.
// - Bit 3 reverses transmit data across four or eight lines.
// - Fields 6:4 and 2:0 pick rx and tx clock delays, reset 000.
// - Wake address low register holds sixteen bits, resets to zero.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module pxrb_eee_mac_regs #(
  parameter int ADDR_WIDTH = 12,
  parameter int DATA_LINES = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // live phy state
  input wire logic linkUp,
  input wire logic gigEeeActive,
  input wire logic fastEeeActive,
  input wire logic mode100,
  input wire logic mode1000,
  input wire logic rgmiiMode,
  input wire logic [1:0] speedSel,
  // led drive
  input wire logic [1:0] ledOn,
  output logic [1:0] ledPin,
  // mode controls
  output logic lowEnergyTenMegModeEn,
  output logic forceGigNoRole,
  output logic rapidLinkLossIndicationEn,
  output logic frameStartEn,
  output logic [2:0] rxClkDelaySel,
  output logic [2:0] txClkDelaySel,
  output logic [11:0] rxClkDelayPs,
  output logic [11:0] txClkDelayPs,
  output logic [15:0] wakeFrameMatchAddrLow,
  // low-power idle path
  input wire logic macTxLpi,
  input wire logic lineRxLpi,
  output logic lineTxLpi,
  output logic macRxLpi,
  output logic testPacketSourceLpi,
  output logic macTxIgnored,
  // data path
  input wire logic [DATA_LINES-1:0] lineRxData,
  output logic [DATA_LINES-1:0] macRxData,
  input wire logic [DATA_LINES-1:0] macTxData,
  output logic [DATA_LINES-1:0] lineTxData
);

  typedef struct packed {
    logic [15:0] pageSel;
    logic [15:0] pwrCtl;
    logic [15:0] macCtl;
    logic [15:0] wakeLow;
    logic ready;
    logic slvErr;
    logic [31:0] rdata;
    logic [1:0] led;
    logic tenMeg;
    logic forceGig;
    logic linkLoss;
    logic frameStart;
    logic [2:0] rxDly;
    logic [2:0] txDly;
    logic [11:0] rxDlyPs;
    logic [11:0] txDlyPs;
    logic [15:0] wakeAddr;
  } pxrb_regs_state_type;

  pxrb_regs_state_type st_r;
  pxrb_regs_state_type st_nxt;

  logic [DATA_LINES-1:0] txDataSel;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // merge write data into a register under byte strobes and a bit mask
  function automatic logic [15:0] mergeWrite(
    input logic [15:0] old,
    input logic [31:0] wdata,
    input logic [3:0] strb,
    input logic [15:0] mask
  );
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}};
    mergeWrite = (old & ~(mask & lanes)) | (wdata[15:0] & mask & lanes);
  endfunction

  // clock delay code to picoseconds
  function automatic logic [11:0] delayPs(input logic [2:0] code);
    case (code)
      3'h0: delayPs = pxrb_pkg::DLY_PS_0;
      3'h1: delayPs = pxrb_pkg::DLY_PS_1;
      3'h2: delayPs = pxrb_pkg::DLY_PS_2;
      3'h3: delayPs = pxrb_pkg::DLY_PS_3;
      3'h4: delayPs = pxrb_pkg::DLY_PS_4;
      3'h5: delayPs = pxrb_pkg::DLY_PS_5;
      3'h6: delayPs = pxrb_pkg::DLY_PS_6;
      default: delayPs = pxrb_pkg::DLY_PS_7;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register file and outputs

  always_comb begin
    logic [9:0] idx;
    logic upperZero;
    logic onPage2;
    logic hitPage;
    logic hitPwr;
    logic hitMac;
    logic hitWake;
    logic doWrite;
    logic [15:0] pwrRead;
    idx = 10'h000;
    upperZero = 1'b0;
    onPage2 = 1'b0;
    hitPage = 1'b0;
    hitPwr = 1'b0;
    hitMac = 1'b0;
    hitWake = 1'b0;
    doWrite = 1'b0;
    pwrRead = 16'h0000;
    st_nxt = st_r;

    idx = 10'(paddr >> 2);
    upperZero = (paddr[1:0] == 2'h0) && ((paddr >> 12) == '0);
    onPage2 = (st_r.pageSel == pxrb_pkg::PAGE_EXT2);
    hitPage = upperZero && (idx == pxrb_pkg::IDX_PAGE_SEL);
    hitPwr = upperZero && onPage2 && (idx == pxrb_pkg::IDX_PWR_CTL);
    hitMac = upperZero && onPage2 && (idx == pxrb_pkg::IDX_MAC_CTL);
    hitWake = upperZero && onPage2 && (idx == pxrb_pkg::IDX_WAKE_LOW);

    pwrRead = st_r.pwrCtl;
    pwrRead[pxrb_pkg::PWR_LINK_UP] = linkUp;
    pwrRead[pxrb_pkg::PWR_GIG_EEE] = gigEeeActive;
    pwrRead[pxrb_pkg::PWR_FAST_EEE] = fastEeeActive;

    // answer prepared in the setup cycle, shown during the access phase
    st_nxt.ready = psel && !penable;
    st_nxt.slvErr = 1'b0;
    if (psel && !penable) begin
      st_nxt.slvErr = !(hitPage || hitPwr || hitMac || hitWake);
      st_nxt.rdata = 32'h00000000;
      if (!pwrite) begin
        if (hitPage) begin
          st_nxt.rdata = {16'h0000, st_r.pageSel};
        end
        if (hitPwr) begin
          st_nxt.rdata = {16'h0000, pwrRead};
        end
        if (hitMac) begin
          st_nxt.rdata = {16'h0000, st_r.macCtl};
        end
        if (hitWake) begin
          st_nxt.rdata = {16'h0000, st_r.wakeLow};
        end
      end
    end

    doWrite = psel && penable && st_r.ready && pwrite;
    if (doWrite && hitPage) begin
      st_nxt.pageSel = mergeWrite(st_r.pageSel, pwdata, pstrb, pxrb_pkg::WMASK_PAGE_SEL);
    end
    if (doWrite && hitPwr) begin
      st_nxt.pwrCtl = mergeWrite(st_r.pwrCtl, pwdata, pstrb, pxrb_pkg::WMASK_PWR_CTL);
    end
    if (doWrite && hitMac) begin
      st_nxt.macCtl = mergeWrite(st_r.macCtl, pwdata, pstrb, pxrb_pkg::WMASK_MAC_CTL);
    end
    if (doWrite && hitWake) begin
      st_nxt.wakeLow = mergeWrite(st_r.wakeLow, pwdata, pstrb, pxrb_pkg::WMASK_WAKE_LOW);
    end

    st_nxt.tenMeg = st_r.pwrCtl[pxrb_pkg::PWR_TEN_MEG_EN];
    // led polarity, active low by default
    st_nxt.led = ~ledOn ^ st_r.pwrCtl[pxrb_pkg::PWR_LED_INV_HI:pxrb_pkg::PWR_LED_INV_LO];
    st_nxt.forceGig = st_r.pwrCtl[pxrb_pkg::PWR_FORCE_GIG] && (speedSel == pxrb_pkg::SPEED_GIG);
    st_nxt.linkLoss = st_r.macCtl[pxrb_pkg::MAC_LINK_LOSS_EN];
    st_nxt.frameStart = st_r.macCtl[pxrb_pkg::MAC_FRAME_START_EN];
    st_nxt.rxDly = st_r.macCtl[pxrb_pkg::MAC_RX_DLY_HI:pxrb_pkg::MAC_RX_DLY_LO];
    st_nxt.txDly = st_r.macCtl[pxrb_pkg::MAC_TX_DLY_HI:pxrb_pkg::MAC_TX_DLY_LO];
    st_nxt.rxDlyPs = delayPs(st_r.macCtl[pxrb_pkg::MAC_RX_DLY_HI:pxrb_pkg::MAC_RX_DLY_LO]);
    st_nxt.txDlyPs = delayPs(st_r.macCtl[pxrb_pkg::MAC_TX_DLY_HI:pxrb_pkg::MAC_TX_DLY_LO]);
    st_nxt.wakeAddr = st_r.wakeLow;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.pageSel <= pxrb_pkg::RST_PAGE_SEL;
      st_r.pwrCtl <= pxrb_pkg::RST_PWR_CTL;
      st_r.macCtl <= pxrb_pkg::RST_MAC_CTL;
      st_r.wakeLow <= pxrb_pkg::RST_WAKE_LOW;
      st_r.led <= 2'h3;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.slvErr;
  assign ledPin = st_r.led;
  assign lowEnergyTenMegModeEn = st_r.tenMeg;
  assign forceGigNoRole = st_r.forceGig;
  assign rapidLinkLossIndicationEn = st_r.linkLoss;
  assign frameStartEn = st_r.frameStart;
  assign rxClkDelaySel = st_r.rxDly;
  assign txClkDelaySel = st_r.txDly;
  assign rxClkDelayPs = st_r.rxDlyPs;
  assign txClkDelayPs = st_r.txDlyPs;
  assign wakeFrameMatchAddrLow = st_r.wakeAddr;

  ////////////////////////////////////////////////////////////////////////////
  // low-power idle gating

  pxrb_lpi_gate u_lpiGate (
    .mclk(mclk),
    .rstn(rstn),
    .mode100(mode100),
    .mode1000(mode1000),
    .forceLpi(st_r.pwrCtl[pxrb_pkg::PWR_FORCE_LPI]),
    .inhTx100(st_r.pwrCtl[pxrb_pkg::PWR_INH_TX_100]),
    .inhRx100(st_r.pwrCtl[pxrb_pkg::PWR_INH_RX_100]),
    .inhTx1000(st_r.pwrCtl[pxrb_pkg::PWR_INH_TX_1000]),
    .inhRx1000(st_r.pwrCtl[pxrb_pkg::PWR_INH_RX_1000]),
    .macTxLpi(macTxLpi),
    .lineRxLpi(lineRxLpi),
    .lineTxLpi(lineTxLpi),
    .macRxLpi(macRxLpi),
    .testPacketSourceLpi(testPacketSourceLpi),
    .macTxIgnored(macTxIgnored)
  );

  ////////////////////////////////////////////////////////////////////////////
  // data bit reversal

  // mac transmit data dropped while idle is forced
  assign txDataSel = st_r.pwrCtl[pxrb_pkg::PWR_FORCE_LPI] ? '0 : macTxData;

  pxrb_bit_reverse #(
    .WIDTH(DATA_LINES)
  ) u_rxReverse (
    .mclk(mclk),
    .rstn(rstn),
    .reverseEn(st_r.macCtl[pxrb_pkg::MAC_RX_REVERSE]),
    .nibbleMode(rgmiiMode),
    .dataIn(lineRxData),
    .dataOut(macRxData)
  );

  pxrb_bit_reverse #(
    .WIDTH(DATA_LINES)
  ) u_txReverse (
    .mclk(mclk),
    .rstn(rstn),
    .reverseEn(st_r.macCtl[pxrb_pkg::MAC_TX_REVERSE]),
    .nibbleMode(rgmiiMode),
    .dataIn(txDataSel),
    .dataOut(lineTxData)
  );

endmodule

// >>> pxrb_pkg.sv
package pxrb_pkg;

  // register indexes; byte address is four times the index
  localparam logic [9:0] IDX_PWR_CTL = 10'h011;
  localparam logic [9:0] IDX_MAC_CTL = 10'h014;
  localparam logic [9:0] IDX_WAKE_LOW = 10'h015;
  localparam logic [9:0] IDX_PAGE_SEL = 10'h01F;

  // page select values
  localparam logic [15:0] PAGE_MAIN = 16'h0000;
  localparam logic [15:0] PAGE_EXT2 = 16'h0002;

  // reset values
  localparam logic [15:0] RST_PWR_CTL = 16'h0000;
  localparam logic [15:0] RST_MAC_CTL = 16'h0000;
  localparam logic [15:0] RST_WAKE_LOW = 16'h0000;
  localparam logic [15:0] RST_PAGE_SEL = 16'h0000;

  // writable bit masks
  localparam logic [15:0] WMASK_PWR_CTL = 16'h8C3F;
  localparam logic [15:0] WMASK_MAC_CTL = 16'h90FF;
  localparam logic [15:0] WMASK_WAKE_LOW = 16'hFFFF;
  localparam logic [15:0] WMASK_PAGE_SEL = 16'hFFFF;

  // power_saving_debug_control fields
  localparam int PWR_TEN_MEG_EN = 15;
  localparam int PWR_LED_INV_HI = 11;
  localparam int PWR_LED_INV_LO = 10;
  localparam int PWR_LINK_UP = 8;
  localparam int PWR_GIG_EEE = 7;
  localparam int PWR_FAST_EEE = 6;
  localparam int PWR_FORCE_GIG = 5;
  localparam int PWR_FORCE_LPI = 4;
  localparam int PWR_INH_TX_100 = 3;
  localparam int PWR_INH_RX_100 = 2;
  localparam int PWR_INH_TX_1000 = 1;
  localparam int PWR_INH_RX_1000 = 0;

  // mac_interface_control fields
  localparam int MAC_LINK_LOSS_EN = 15;
  localparam int MAC_FRAME_START_EN = 12;
  localparam int MAC_RX_REVERSE = 7;
  localparam int MAC_RX_DLY_HI = 6;
  localparam int MAC_RX_DLY_LO = 4;
  localparam int MAC_TX_REVERSE = 3;
  localparam int MAC_TX_DLY_HI = 2;
  localparam int MAC_TX_DLY_LO = 0;

  // speed bits {bit6, bit13} of basic control that select 1000 Mb/s
  localparam logic [1:0] SPEED_GIG = 2'b10;

  // clock delay per code, in picoseconds
  localparam logic [11:0] DLY_PS_0 = 12'h0C8;
  localparam logic [11:0] DLY_PS_1 = 12'h320;
  localparam logic [11:0] DLY_PS_2 = 12'h44C;
  localparam logic [11:0] DLY_PS_3 = 12'h6A4;
  localparam logic [11:0] DLY_PS_4 = 12'h7D0;
  localparam logic [11:0] DLY_PS_5 = 12'h8FC;
  localparam logic [11:0] DLY_PS_6 = 12'hA28;
  localparam logic [11:0] DLY_PS_7 = 12'hD48;

endpackage

// >>> pxrb_bit_reverse.sv
`timescale 1ns/1ps
module pxrb_bit_reverse #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // control
  input wire logic reverseEn,
  input wire logic nibbleMode,
  // data
  input wire logic [WIDTH-1:0] dataIn,
  output logic [WIDTH-1:0] dataOut
);

  typedef struct packed {
    logic [WIDTH-1:0] data;
  } pxrb_rev_state_type;

  pxrb_rev_state_type st_r;
  pxrb_rev_state_type st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    st_nxt.data = dataIn;
    if (reverseEn) begin
      for (int i = 0; i < WIDTH; i++) begin
        if (nibbleMode) begin
          // four-line mode swaps the low nibble only
          if (i < 4) begin
            st_nxt.data[i] = dataIn[3-i];
          end
        end else begin
          st_nxt.data[i] = dataIn[WIDTH-1-i];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dataOut = st_r.data;

endmodule

// >>> pxrb_lpi_gate.sv
`timescale 1ns/1ps
module pxrb_lpi_gate (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // link mode
  input wire logic mode100,
  input wire logic mode1000,
  // controls
  input wire logic forceLpi,
  input wire logic inhTx100,
  input wire logic inhRx100,
  input wire logic inhTx1000,
  input wire logic inhRx1000,
  // low-power idle indications
  input wire logic macTxLpi,
  input wire logic lineRxLpi,
  output logic lineTxLpi,
  output logic macRxLpi,
  output logic testPacketSourceLpi,
  output logic macTxIgnored
);

  typedef struct packed {
    logic lineTx;
    logic macRx;
    logic srcLpi;
    logic ignore;
  } pxrb_lpi_state_type;

  pxrb_lpi_state_type st_r;
  pxrb_lpi_state_type st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    st_nxt.srcLpi = forceLpi;
    st_nxt.ignore = forceLpi;
    st_nxt.lineTx = forceLpi | (macTxLpi & ~(mode100 & inhTx100) & ~(mode1000 & inhTx1000));
    st_nxt.macRx = lineRxLpi & ~(mode100 & inhRx100) & ~(mode1000 & inhRx1000);
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lineTxLpi = st_r.lineTx;
  assign macRxLpi = st_r.macRx;
  assign testPacketSourceLpi = st_r.srcLpi;
  assign macTxIgnored = st_r.ignore;

endmodule

// >>> pxrb_mac_model.sv
`timescale 1ns/1ps
module pxrb_mac_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // requests from the bench
  input wire logic [7:0] sendData,
  input wire logic sendLpi,
  // mac transmit side
  output logic [7:0] macTxData,
  output logic macTxLpi
);
  // launches data off its own flop, one cycle after the request
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      macTxData <= 8'h00;
      macTxLpi <= 1'h0;
    end else begin
      macTxData <= sendData;
      macTxLpi <= sendLpi;
    end
  end
endmodule

// >>> pxrb_eee_mac_regs_props.sv
`timescale 1ns/1ps
module pxrb_eee_mac_regs_props #(
  parameter int ADDR_WIDTH = 12
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // controls
  input wire logic [1:0] speedSel,
  input wire logic forceGigNoRole,
  input wire logic [2:0] rxClkDelaySel,
  input wire logic [2:0] txClkDelaySel,
  input wire logic [11:0] rxClkDelayPs,
  input wire logic [11:0] txClkDelayPs,
  // low-power idle
  input wire logic macTxLpi,
  input wire logic lineRxLpi,
  input wire logic lineTxLpi,
  input wire logic macRxLpi,
  input wire logic testPacketSourceLpi,
  input wire logic macTxIgnored
);
  localparam logic [11:0] PS [8] = '{12'h0C8, 12'h320, 12'h44C, 12'h6A4,
                                      12'h7D0, 12'h8FC, 12'hA28, 12'hD48};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  property p_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("no single-cycle answer after setup");
  property p_misalign;
    pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0;
  endproperty
  a_misalign: assert property (p_misalign)
    else $error("misaligned access not refused");
  property p_reserved;
    pready && !pslverr |-> prdata[31:16] == 16'h0
      && (paddr != 12'h044 || (prdata[14:12] == 3'h0 && !prdata[9]))
      && (paddr != 12'h050 || (prdata[14:13] == 2'h0 && prdata[11:8] == 4'h0));
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits read nonzero");
  property p_gig;
    forceGigNoRole |-> $past(speedSel) == 2'h2;
  endproperty
  a_gig: assert property (p_gig)
    else $error("forced gigabit without speed bits 10");
  property p_force;
    testPacketSourceLpi |-> macTxIgnored && lineTxLpi;
  endproperty
  a_force: assert property (p_force)
    else $error("forced idle not sent on line");
  property p_tx_lpi;
    lineTxLpi && !testPacketSourceLpi |-> $past(macTxLpi);
  endproperty
  a_tx_lpi: assert property (p_tx_lpi)
    else $error("line idle without mac idle");
  property p_rx_lpi;
    macRxLpi |-> $past(lineRxLpi);
  endproperty
  a_rx_lpi: assert property (p_rx_lpi)
    else $error("mac idle without line idle");
  property p_dly;
    $past(rstn) |-> rxClkDelayPs == PS[rxClkDelaySel] && txClkDelayPs == PS[txClkDelaySel];
  endproperty
  a_dly: assert property (p_dly)
    else $error("clock delay does not match code");
endmodule

// >>> pxrb_eee_mac_regs_test.sv
`timescale 1ns/1ps
module pxrb_eee_mac_regs_test;
  logic mclk, rstn, psel, penable, pwrite, pready, pslverr, rdErr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdData;
  logic [3:0] pstrb;
  logic linkUp, gigEeeActive, fastEeeActive, mode100, mode1000, rgmiiMode;
  logic [1:0] speedSel, ledOn, ledPin;
  logic lowEnergyTenMegModeEn, forceGigNoRole, rapidLinkLossIndicationEn, frameStartEn;
  logic [2:0] rxClkDelaySel, txClkDelaySel;
  logic [11:0] rxClkDelayPs, txClkDelayPs;
  logic [15:0] wakeFrameMatchAddrLow;
  logic macTxLpi, lineRxLpi, lineTxLpi, macRxLpi, testPacketSourceLpi, macTxIgnored, sendLpi;
  logic [7:0] lineRxData, macRxData, macTxData, lineTxData, sendData;
  int failures, compares;
  pxrb_eee_mac_regs u_dut (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .linkUp, .gigEeeActive, .fastEeeActive, .mode100, .mode1000,
    .rgmiiMode, .speedSel, .ledOn, .ledPin, .lowEnergyTenMegModeEn, .forceGigNoRole,
    .rapidLinkLossIndicationEn, .frameStartEn, .rxClkDelaySel, .txClkDelaySel, .rxClkDelayPs,
    .txClkDelayPs, .wakeFrameMatchAddrLow, .macTxLpi, .lineRxLpi, .lineTxLpi, .macRxLpi,
    .testPacketSourceLpi, .macTxIgnored, .lineRxData, .macRxData, .macTxData, .lineTxData);
  pxrb_mac_model u_mac (.mclk, .rstn, .sendData, .sendLpi, .macTxData, .macTxLpi);
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) begin
      failures++;
      $display("Error at %0t: no bus answer", $time);
      print_verdict;
    end
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic er);
    apb(1'h0, a, 32'h0);
    chk(rdData, e);
    chk(rdErr, er);
  endtask
  function automatic logic [7:0] rev(input logic [7:0] d, input logic en, input logic r);
    logic [7:0] v;
    v = d;
    for (int i = 0; i < 8; i++) begin
      if (en && (!r || i < 4)) begin
        v[i] = r ? d[3 - i] : d[7 - i];
      end
    end
    return v;
  endfunction
  function automatic logic [11:0] dlyExp(input logic [2:0] c);
    case (c)
      3'h0: return pxrb_pkg::DLY_PS_0;
      3'h1: return pxrb_pkg::DLY_PS_1;
      3'h2: return pxrb_pkg::DLY_PS_2;
      3'h3: return pxrb_pkg::DLY_PS_3;
      3'h4: return pxrb_pkg::DLY_PS_4;
      3'h5: return pxrb_pkg::DLY_PS_5;
      3'h6: return pxrb_pkg::DLY_PS_6;
      default: return pxrb_pkg::DLY_PS_7;
    endcase
  endfunction
  ////////////////////////////////////////
  task automatic t_reset;
    chk(ledPin, 2'h3);
    rd(12'h044, 32'h0, 1'h1);
    apb(1'h1, 12'h07C, 32'h2);
    rd(12'h044, 32'h0, 1'h0);
    rd(12'h050, 32'h0, 1'h0);
    rd(12'h054, 32'h0, 1'h0);
  endtask
  task automatic t_access;
    linkUp <= 1'h1;
    gigEeeActive <= 1'h1;
    apb(1'h1, 12'h044, 32'hFFFFFFFF);
    rd(12'h044, 32'h8DBF, 1'h0);
    linkUp <= 1'h0;
    gigEeeActive <= 1'h0;
    fastEeeActive <= 1'h1;
    rd(12'h044, 32'h8C7F, 1'h0);
    apb(1'h1, 12'h050, 32'hFFFF);
    rd(12'h050, 32'h90FF, 1'h0);
    apb(1'h1, 12'h054, 32'hA5C3);
    rd(12'h054, 32'hA5C3, 1'h0);
    pstrb <= 4'h1;
    apb(1'h1, 12'h054, 32'h5A5A);
    pstrb <= 4'hF;
    rd(12'h054, 32'hA55A, 1'h0);
    apb(1'h1, 12'h048, 32'h1234);
    rd(12'h048, 32'h0, 1'h1);
    rd(12'h046, 32'h0, 1'h1);
    tick(2);
    chk(lowEnergyTenMegModeEn, 1'h1);
    chk(rapidLinkLossIndicationEn, 1'h1);
    chk(frameStartEn, 1'h1);
    chk(wakeFrameMatchAddrLow, 16'hA55A);
    // force bit goes first, before the packet source would be disabled
    apb(1'h1, 12'h044, 32'h0);
    apb(1'h1, 12'h050, 32'h0);
    tick(2);
    chk(frameStartEn, 1'h0);
  endtask
  task automatic t_delay;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      apb(1'h1, 12'h050, {25'h0, c, 1'h0, ~c});
      tick(2);
      chk(rxClkDelaySel, c);
      chk(txClkDelaySel, 3'(~c));
      chk(rxClkDelayPs, dlyExp(c));
      chk(txClkDelayPs, dlyExp(3'(~c)));
    end
  endtask
  task automatic t_reverse;
    for (int k = 0; k < 4; k++) begin
      apb(1'h1, 12'h050, k[0] ? 32'h88 : 32'h0);
      rgmiiMode <= k[1];
      lineRxData <= 8'h1D;
      sendData <= 8'h36;
      tick(3);
      chk(macRxData, rev(8'h1D, k[0], k[1]));
      chk(lineTxData, rev(8'h36, k[0], k[1]));
    end
  endtask
  task automatic t_lpi;
    sendLpi <= 1'h1;
    lineRxLpi <= 1'h1;
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 4; i++) begin
        apb(1'h1, 12'h044, 32'h1 << i);
        mode100 <= (i >= 2) ^ m[0];
        mode1000 <= (i < 2) ^ m[0];
        tick(3);
        chk(lineTxLpi, m[0] || !i[0]);
        chk(macRxLpi, m[0] || i[0]);
      end
    end
    apb(1'h1, 12'h044, 32'h10);
    sendLpi <= 1'h0;
    tick(3);
    chk(testPacketSourceLpi, 1'h1);
    chk(macTxIgnored, 1'h1);
    chk(lineTxLpi, 1'h1);
    chk(lineTxData, 8'h00);
    apb(1'h1, 12'h044, 32'h0);
    tick(3);
    chk(lineTxLpi, 1'h0);
  endtask
  task automatic t_led_gig;
    ledOn <= 2'h1;
    for (int v = 0; v < 4; v++) begin
      apb(1'h1, 12'h044, 32'(v) << 10);
      tick(3);
      chk(ledPin, 2'h2 ^ 2'(v));
    end
    apb(1'h1, 12'h044, 32'h20);
    speedSel <= 2'h2;
    tick(3);
    chk(forceGigNoRole, 1'h1);
    speedSel <= 2'h1;
    tick(2);
    chk(forceGigNoRole, 1'h0);
  endtask
  task automatic t_midreset;
    rstn <= 1'h0;
    tick(2);
    rstn <= 1'h1;
    chk(ledPin, 2'h3);
    chk(wakeFrameMatchAddrLow, 16'h0);
    rd(12'h054, 32'h0, 1'h1);
    apb(1'h1, 12'h07C, 32'h2);
    rd(12'h054, 32'h0, 1'h0);
    rd(12'h050, 32'h0, 1'h0);
  endtask
  task automatic print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    $display("Error at %0t: timeout", $time);
    print_verdict;
  end
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, linkUp, gigEeeActive, fastEeeActive} = '0;
    {mode100, mode1000, rgmiiMode, speedSel, ledOn, lineRxLpi, lineRxData} = '0;
    {sendData, sendLpi, failures, compares} = '0;
    pstrb = 4'hF;
    repeat (6) @(posedge mclk);
    rstn <= 1'h1;
    t_reset;
    t_access;
    t_delay;
    t_reverse;
    t_lpi;
    t_led_gig;
    t_midreset;
    print_verdict;
  end
endmodule
bind pxrb_eee_mac_regs pxrb_eee_mac_regs_props #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (.mclk,
  .rstn, .psel, .penable, .paddr, .prdata, .pready, .pslverr, .speedSel, .forceGigNoRole,
  .rxClkDelaySel, .txClkDelaySel, .rxClkDelayPs, .txClkDelayPs, .macTxLpi, .lineRxLpi,
  .lineTxLpi, .macRxLpi, .testPacketSourceLpi, .macTxIgnored);
